// *** logic/ddr_pin_pkg.sv ***
package ddr_pin_pkg;

  // Pin widths of the memory interface, bank count and FIFO depth.
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int BANK_W = 3;
  localparam int BANKS = 8;
  localparam int FIFO_DEPTH = 16;

  // Address bit positions that carry meaning during certain commands.
  localparam int PRE_ALL_BIT = 10;
  localparam int AUTO_PRE_BIT = 10;

  // Field positions inside ext_mode_reg_one.
  localparam int EMR_STROBE_N_OFF_BIT = 10;
  localparam int EMR_ROS_BIT = 11;
  localparam int EMR_RTT_LO_BIT = 2;
  localparam int EMR_RTT_HI_BIT = 6;

  // Bank codes that select the target of a mode set.
  localparam logic [2:0] MR_BASE_SEL = 3'h0;
  localparam logic [2:0] MR_EXT1_SEL = 3'h1;

  // Reset values of the mode registers.
  localparam logic [13:0] MODE_RST = 14'h0000;
  localparam logic [13:0] EMR1_RST = 14'h0000;

  // Command code built as {select_n, row_n, col_n, we_n}.
  typedef enum logic [3:0] {
    CMD_MODE_SET = 4'h0,
    CMD_REFRESH = 4'h1,
    CMD_PRECHARGE = 4'h2,
    CMD_ACTIVATE = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_READ = 4'h5,
    CMD_NOP = 4'h7
  } cmd_t;

  // Read burst sequencer states.
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_BEAT1 = 3'b010,
    RD_TAIL = 3'b100
  } rd_state_t;

  // One decoded command as handed to the core side.
  typedef struct packed {
    cmd_t cmd;
    logic [2:0] bank;
    logic [13:0] addr;
    logic [31:0] data;
    logic [3:0] keep;
  } rec_t;

endpackage : ddr_pin_pkg

// *** logic/ddr_pin_device.sv ***
`timescale 1ns/1ps

// Three-stage synchroniser; the output moves once stages two and three agree.
module sync3 (
  input wire logic clock, // Destination clock.
  input wire logic rst, // Synchronous reset of the destination.
  input wire logic d, // Level from another domain.
  output logic q // Filtered level.
);
  logic [2:0] stage_r; // Stage 0 is read only by stage 1.

  // Shift the level through the chain.
  always_ff @(posedge clock) begin
    if (rst) begin
      stage_r <= 3'h0;
    end else begin
      stage_r <= {stage_r[1:0], d};
    end
  end

  // Take the level only when the two late stages agree.
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= 1'b0;
    end else if (stage_r[1] == stage_r[2]) begin
      q <= stage_r[2];
    end
  end
endmodule : sync3

// Flop-based FIFO with a registered output stage.
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock, // Clock.
  input wire logic rst, // Synchronous reset.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Space available.
  input wire logic [WIDTH-1:0] in_data, // Write word.
  output logic out_valid, // Output word valid.
  input wire logic out_ready, // Drain accepts.
  output logic [WIDTH-1:0] out_data // Output word.
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH]; // Storage.
  logic [AW-1:0] wr_ptr_r; // Write index.
  logic [AW-1:0] rd_ptr_r; // Read index.
  logic [AW:0] count_r; // Words held in storage.
  logic push; // Word enters.
  logic pop; // Word moves to the output stage.

  assign in_ready = (count_r != FULL);
  assign push = in_valid && in_ready;
  assign pop = (count_r != '0) && (!out_valid || out_ready);

  // Storage write.
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill count; depth must be a power of two so pointers wrap.
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Output stage holds its word until the drain takes it.
  always_ff @(posedge clock) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_r[rd_ptr_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : sync_fifo

module ddr_pin_device
  import ddr_pin_pkg::*;
(
  input wire logic clock, // Core clock.
  input wire logic rst, // Core synchronous reset.
  input wire logic org_wide, // High for sixteen-bit organisation.
  output rec_t rec_data, // Decoded command toward the core.
  output logic rec_valid, // rec_data valid.
  input wire logic rec_ready, // Core accepts rec_data.
  output logic [BANKS-1:0] bank_open, // Banks with an open row.
  output logic [ADDR_W-1:0] base_mode, // Copy of the base mode register.
  output logic [ADDR_W-1:0] ext_mode_one, // Copy of ext_mode_reg_one.
  output logic dropped, // Sticky: a command was lost.
  input wire logic dropped_clear, // Clears dropped.
  input wire logic mem_clk, // Link clock from the controller.
  input wire logic clk_enable, // Clock enable pin.
  input wire logic chip_sel_n, // Chip select, active low.
  input wire logic row_strobe_n, // Row strobe, active low.
  input wire logic col_strobe_n, // Column strobe, active low.
  input wire logic write_en_n, // Write enable, active low.
  input wire logic [BANK_W-1:0] bank_select, // Bank inputs.
  input wire logic [ADDR_W-1:0] addr_in, // Address inputs.
  input wire logic die_termination_ctrl, // Termination request.
  input wire logic lower_byte_mask, // Mask of byte 0.
  input wire logic upper_byte_mask, // Mask of byte 1.
  input wire logic [DATA_W-1:0] data_lines_in, // Data pins, input side.
  output logic [DATA_W-1:0] data_lines_out, // Data pins, output side.
  output logic [1:0] data_lines_oe, // Data enable per byte.
  input wire logic lower_lane_strobe_in, // Lower strobe, input side.
  output logic lower_lane_strobe_out, // Lower strobe, output side.
  output logic lower_lane_strobe_oe, // Lower strobe enable.
  output logic lower_lane_strobe_n_out, // Lower complement strobe.
  output logic lower_lane_strobe_n_oe, // Lower complement enable.
  input wire logic upper_lane_strobe_in, // Upper strobe, input side.
  output logic upper_lane_strobe_out, // Upper strobe, output side.
  output logic upper_lane_strobe_oe, // Upper strobe enable.
  output logic upper_lane_strobe_n_out, // Upper complement strobe.
  output logic upper_lane_strobe_n_oe, // Upper complement enable.
  output logic read_only_strobe_out, // Read-only strobe.
  output logic read_only_strobe_oe, // Read-only strobe enable.
  output logic term_on // Termination switched on.
);

  // Termination is on when either termination field bit is set.
  function automatic logic rtt_on(input logic [ADDR_W-1:0] emr);
    rtt_on = emr[EMR_RTT_LO_BIT] | emr[EMR_RTT_HI_BIT];
  endfunction : rtt_on

  // Bytes kept from one beat; the upper byte exists only when wide.
  function automatic logic [1:0] keep_of(input logic [1:0] mask, input logic wide,
                                         input logic mask_en);
    keep_of = {wide & !(mask[1] & mask_en), !(mask[0] & mask_en)};
  endfunction : keep_of

  // Strobe enables {ros, up_n, up, lo_n, lo} for a burst that is on or off.
  function automatic logic [4:0] strobe_en(input logic on, input logic wide,
                                           input logic [ADDR_W-1:0] emr);
    logic comp;
    comp = on & !emr[EMR_STROBE_N_OFF_BIT];
    strobe_en = {on & !wide & emr[EMR_ROS_BIT], comp & wide, on & wide, comp, on};
  endfunction : strobe_en

  logic link_rst; // Core reset as seen on the link clock.
  logic wide_s; // Organisation strap on the link clock.
  logic ack_s; // Core acknowledge toggle on the link clock.
  logic req_s; // Link request toggle on the core clock.
  logic drop_s; // Link drop toggle on the core clock.
  logic req_t_r; // Link request toggle.
  logic drop_t_r; // Link drop toggle.
  logic ack_t_r; // Core acknowledge toggle.

  // The link reset has no reset of its own; it settles while rst is held.
  sync3 u_rst_sync (.clock(mem_clk), .rst(1'b0), .d(rst), .q(link_rst));
  sync3 u_org_sync (.clock(mem_clk), .rst(link_rst), .d(org_wide), .q(wide_s));
  sync3 u_ack_sync (.clock(mem_clk), .rst(link_rst), .d(ack_t_r), .q(ack_s));
  sync3 u_req_sync (.clock(clock), .rst(rst), .d(req_t_r), .q(req_s));
  sync3 u_drop_sync (.clock(clock), .rst(rst), .d(drop_t_r), .q(drop_s));

  // Link side: pins are synchronous to mem_clk and need no synchroniser.
  cmd_t cmd; // Decoded command code.
  logic cmd_valid; // Command present this edge.
  logic mset; // Mode set command.
  logic fwd_cmd; // Command forwarded at once.
  logic busy; // Previous record not yet acknowledged.
  logic [ADDR_W-1:0] emr1_r; // ext_mode_reg_one.
  logic term_on_r; // Termination state.
  logic [31:0] mem_r [BANKS]; // One two-beat word per bank.
  logic wr_pend_r; // Write command seen last edge.
  logic wr_beat_r; // Both write beats captured.
  logic [BANK_W-1:0] wr_bank_r; // Bank of the write.
  logic [ADDR_W-1:0] wr_addr_r; // Column of the write.
  logic [DATA_W-1:0] rise_data_r; // Beat 0.
  logic [1:0] rise_mask_r; // Mask with beat 0.
  logic [DATA_W-1:0] fall_data_r; // Beat 1, taken on the falling edge.
  logic [1:0] fall_mask_r; // Mask with beat 1.
  logic mask_en; // Mask function active.
  logic [1:0] keep_rise; // Bytes kept from beat 0.
  logic [1:0] keep_fall; // Bytes kept from beat 1.
  rec_t new_rec; // Record built this edge.
  rec_t rec_r; // Record held for the core.
  rd_state_t rd_state_r; // Read sequencer.
  logic [DATA_W-1:0] data_out_r; // Read data driven.
  logic [DATA_W-1:0] rd_hi_r; // Second read beat.
  logic [1:0] data_oe_r; // Data enable per byte.
  logic strobe_r; // True strobe level.
  logic strobe_n_r; // Complement strobe level.
  logic [4:0] strobe_oe_r; // Strobe enables.

  // Commands need clock enable and a low select; the controller holds
  // clock enable high through accesses, so no access is cut short.
  assign cmd_valid = clk_enable && !chip_sel_n;
  assign cmd = cmd_t'({chip_sel_n, row_strobe_n, col_strobe_n, write_en_n});
  assign mset = cmd_valid && (cmd == CMD_MODE_SET);
  assign fwd_cmd = cmd_valid && (cmd <= CMD_READ) && (cmd != CMD_WRITE);
  assign busy = (req_t_r != ack_s);

  // Mode set to the first extended register takes the address as op code.
  always_ff @(posedge mem_clk) begin
    if (link_rst) begin
      emr1_r <= EMR1_RST;
    end else if (mset && (bank_select == MR_EXT1_SEL)) begin
      emr1_r <= addr_in;
    end
  end

  // Termination follows the registered input only while the mode allows it.
  always_ff @(posedge mem_clk) begin
    if (link_rst) begin
      term_on_r <= 1'b0;
    end else begin
      term_on_r <= die_termination_ctrl && rtt_on(emr1_r);
    end
  end

  // Falling edge half of each write beat pair, with its mask.
  always_ff @(negedge mem_clk) begin
    fall_data_r <= data_lines_in;
    fall_mask_r <= {upper_byte_mask, lower_byte_mask};
  end

  // Write timing: data follows one edge after the command.
  // Two writes must be at least two edges apart, or the bank is overwritten.
  always_ff @(posedge mem_clk) begin
    if (link_rst) begin
      wr_pend_r <= 1'b0;
      wr_beat_r <= 1'b0;
    end else begin
      wr_pend_r <= cmd_valid && (cmd == CMD_WRITE);
      wr_beat_r <= wr_pend_r;
    end
  end

  // Bank, column and rising edge beat with its mask.
  always_ff @(posedge mem_clk) begin
    if (cmd_valid && (cmd == CMD_WRITE)) begin
      wr_bank_r <= bank_select;
      wr_addr_r <= addr_in;
    end
    if (wr_pend_r) begin
      rise_data_r <= data_lines_in;
      rise_mask_r <= {upper_byte_mask, lower_byte_mask};
    end
  end

  // Byte-wide parts share the mask pin with the read-only strobe.
  assign mask_en = wide_s || !emr1_r[EMR_ROS_BIT];
  assign keep_rise = keep_of(rise_mask_r, wide_s, mask_en);
  assign keep_fall = keep_of(fall_mask_r, wide_s, mask_en);

  // Store only the unmasked bytes of each beat.
  always_ff @(posedge mem_clk) begin
    if (wr_beat_r) begin
      for (int i = 0; i < 2; i++) begin
        if (keep_rise[i]) begin
          mem_r[wr_bank_r][8*i +: 8] <= rise_data_r[8*i +: 8];
        end
        if (keep_fall[i]) begin
          mem_r[wr_bank_r][16+8*i +: 8] <= fall_data_r[8*i +: 8];
        end
      end
    end
  end

  // Build the record: a finished write has priority over a new command.
  always_comb begin
    new_rec = '0;
    if (wr_beat_r) begin
      new_rec.cmd = CMD_WRITE;
      new_rec.bank = wr_bank_r;
      new_rec.addr = wr_addr_r;
      new_rec.data = {fall_data_r, rise_data_r};
      new_rec.keep = {keep_fall, keep_rise};
    end else begin
      new_rec.cmd = cmd;
      new_rec.bank = bank_select;
      new_rec.addr = addr_in;
    end
  end

  // Hand records over by toggle; the record stays still until acknowledged.
  // Anything arriving while busy, or colliding with a write, is dropped.
  always_ff @(posedge mem_clk) begin
    if (link_rst) begin
      req_t_r <= 1'b0;
      drop_t_r <= 1'b0;
      rec_r <= '0;
    end else begin
      if ((wr_beat_r || fwd_cmd) && !busy) begin
        rec_r <= new_rec;
        req_t_r <= ~req_t_r;
      end
      if (((wr_beat_r || fwd_cmd) && busy) || (wr_beat_r && fwd_cmd)) begin
        drop_t_r <= ~drop_t_r;
      end
    end
  end

  // Read burst: two beats, strobe toggles with each data change.
  always_ff @(posedge mem_clk) begin
    if (link_rst) begin
      rd_state_r <= RD_IDLE;
      data_out_r <= '0;
      rd_hi_r <= '0;
      data_oe_r <= 2'h0;
      strobe_r <= 1'b0;
      strobe_n_r <= 1'b1;
      strobe_oe_r <= 5'h00;
    end else begin
      case (rd_state_r)
        RD_IDLE: begin
          if (cmd_valid && (cmd == CMD_READ)) begin
            data_out_r <= mem_r[bank_select][15:0];
            rd_hi_r <= mem_r[bank_select][31:16];
            data_oe_r <= {wide_s, 1'b1};
            strobe_r <= 1'b1;
            strobe_n_r <= 1'b0;
            strobe_oe_r <= strobe_en(1'b1, wide_s, emr1_r);
            rd_state_r <= RD_BEAT1;
          end
        end
        RD_BEAT1: begin
          data_out_r <= rd_hi_r;
          strobe_r <= 1'b0;
          strobe_n_r <= 1'b1;
          rd_state_r <= RD_TAIL;
        end
        RD_TAIL: begin
          data_oe_r <= 2'h0;
          strobe_oe_r <= strobe_en(1'b0, wide_s, emr1_r);
          rd_state_r <= RD_IDLE;
        end
        default: begin
          rd_state_r <= RD_IDLE;
        end
      endcase
    end
  end

  assign term_on = term_on_r;
  assign data_lines_out = data_out_r;
  assign data_lines_oe = data_oe_r;
  assign lower_lane_strobe_out = strobe_r;
  assign upper_lane_strobe_out = strobe_r;
  assign read_only_strobe_out = strobe_r;
  assign lower_lane_strobe_n_out = strobe_n_r;
  assign upper_lane_strobe_n_out = strobe_n_r;
  assign lower_lane_strobe_oe = strobe_oe_r[0];
  assign lower_lane_strobe_n_oe = strobe_oe_r[1];
  assign upper_lane_strobe_oe = strobe_oe_r[2];
  assign upper_lane_strobe_n_oe = strobe_oe_r[3];
  assign read_only_strobe_oe = strobe_oe_r[4];

  a_term_follow: assert property (@(posedge mem_clk) disable iff (link_rst)
    die_termination_ctrl && rtt_on(emr1_r) && !mset |=> term_on_r)
    else $error("termination not switched on");
  a_term_ignored: assert property (@(posedge mem_clk) disable iff (link_rst)
    !rtt_on(emr1_r) && !mset |=> !term_on_r)
    else $error("termination on while disabled");
  a_deselect_masks: assert property (@(posedge mem_clk) disable iff (link_rst)
    chip_sel_n && (rd_state_r == RD_IDLE) |=> (rd_state_r == RD_IDLE) && $stable(emr1_r))
    else $error("command taken while deselected");
  a_read_burst: assert property (@(posedge mem_clk) disable iff (link_rst)
    cmd_valid && (cmd == CMD_READ) && (rd_state_r == RD_IDLE)
    |=> data_oe_r[0] && strobe_r ##1 data_oe_r[0] && !strobe_r ##1 !data_oe_r[0])
    else $error("read burst shape wrong");
  a_emr_write: assert property (@(posedge mem_clk) disable iff (link_rst)
    mset && (bank_select == MR_EXT1_SEL) |=> emr1_r == $past(addr_in))
    else $error("extended mode op code not taken");
  a_mask_drop: assert property (@(posedge mem_clk) disable iff (link_rst)
    wr_beat_r && rise_mask_r[0] && mask_en && !busy |=> !rec_r.keep[0])
    else $error("masked beat kept");
  a_comp_strobe: assert property (@(posedge mem_clk) disable iff (link_rst)
    $rose(data_oe_r[0]) |-> strobe_oe_r[1] == !emr1_r[EMR_STROBE_N_OFF_BIT])
    else $error("complement strobe enable wrong");
  a_ros_bytewide: assert property (@(posedge mem_clk) disable iff (link_rst)
    strobe_oe_r[4] |-> !wide_s && emr1_r[EMR_ROS_BIT] && data_oe_r[0])
    else $error("read-only strobe driven wrongly");
  a_upper_lane: assert property (@(posedge mem_clk) disable iff (link_rst)
    strobe_oe_r[2] |-> wide_s && data_oe_r[1])
    else $error("upper strobe without upper byte");
  c_masked_write: cover property (@(posedge mem_clk) disable iff (link_rst)
    wr_beat_r && (rise_mask_r != 2'h0));
  c_strobed_write: cover property (@(posedge mem_clk) disable iff (link_rst)
    wr_pend_r && (lower_lane_strobe_in || upper_lane_strobe_in));
  c_read_done: cover property (@(posedge mem_clk) disable iff (link_rst)
    rd_state_r == RD_TAIL);

  // Core side.
  logic push_ok; // Record moves into the FIFO.
  logic fifo_in_ready; // FIFO has space.
  logic drop_seen_r; // Last drop toggle seen.
  logic drop_evt; // New drop reported.
  logic [BANKS-1:0] bank_open_r; // Open row per bank.
  logic [ADDR_W-1:0] base_mode_r; // Base mode copy.
  logic [ADDR_W-1:0] ext_mode_r; // Extended mode copy.
  logic dropped_r; // Sticky drop flag.

  // A full FIFO holds back the acknowledge, which backs up the link.
  assign push_ok = (req_s != ack_t_r) && fifo_in_ready;
  assign drop_evt = (drop_s != drop_seen_r);

  // Acknowledge once the record is safely in the FIFO.
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_t_r <= 1'b0;
    end else if (push_ok) begin
      ack_t_r <= req_s;
    end
  end

  // Track open rows per bank from accepted records.
  always_ff @(posedge clock) begin
    if (rst) begin
      bank_open_r <= '0;
    end else if (push_ok) begin
      case (rec_r.cmd)
        CMD_ACTIVATE: bank_open_r[rec_r.bank] <= 1'b1;
        CMD_PRECHARGE: begin
          if (rec_r.addr[PRE_ALL_BIT]) begin
            bank_open_r <= '0;
          end else begin
            bank_open_r[rec_r.bank] <= 1'b0;
          end
        end
        CMD_READ, CMD_WRITE: begin
          if (rec_r.addr[AUTO_PRE_BIT]) begin
            bank_open_r[rec_r.bank] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Mode copies for the core; the bank code picks the register.
  always_ff @(posedge clock) begin
    if (rst) begin
      base_mode_r <= MODE_RST;
      ext_mode_r <= EMR1_RST;
    end else if (push_ok && (rec_r.cmd == CMD_MODE_SET)) begin
      if (rec_r.bank == MR_BASE_SEL) begin
        base_mode_r <= rec_r.addr;
      end else if (rec_r.bank == MR_EXT1_SEL) begin
        ext_mode_r <= rec_r.addr;
      end
    end
  end

  // Sticky drop flag; a new drop wins over a clear in the same cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      drop_seen_r <= 1'b0;
      dropped_r <= 1'b0;
    end else begin
      drop_seen_r <= drop_s;
      if (drop_evt) begin
        dropped_r <= 1'b1;
      end else if (dropped_clear) begin
        dropped_r <= 1'b0;
      end
    end
  end

  sync_fifo #(.WIDTH($bits(rec_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(req_s != ack_t_r),
    .in_ready(fifo_in_ready),
    .in_data(rec_r),
    .out_valid(rec_valid),
    .out_ready(rec_ready),
    .out_data(rec_data)
  );

  assign bank_open = bank_open_r;
  assign base_mode = base_mode_r;
  assign ext_mode_one = ext_mode_r;
  assign dropped = dropped_r;

  a_precharge_all: assert property (@(posedge clock) disable iff (rst)
    push_ok && (rec_r.cmd == CMD_PRECHARGE) && rec_r.addr[PRE_ALL_BIT] |=> bank_open_r == '0)
    else $error("precharge all left a bank open");
  a_activate_bank: assert property (@(posedge clock) disable iff (rst)
    push_ok && (rec_r.cmd == CMD_ACTIVATE) |=> bank_open_r[$past(rec_r.bank)])
    else $error("activated bank not open");
  a_drop_sticky: assert property (@(posedge clock) disable iff (rst)
    drop_evt |=> dropped_r ##1 (dropped_r || $past(dropped_clear)))
    else $error("drop flag not held");
  c_fifo_stall: cover property (@(posedge clock) disable iff (rst)
    (req_s != ack_t_r) && !fifo_in_ready);

endmodule : ddr_pin_device

// *** tb/ddr_ctrl_model.sv ***
`timescale 1ns/1ps
// Controller stand-in: drives command, bank, address, mask and write data on the link clock.
module ddr_ctrl_model
  import ddr_pin_pkg::*;
(
  input wire logic mem_clk, // Link clock.
  output logic [3:0] code, // Command code {select_n, row_n, col_n, we_n}.
  output logic [BANK_W-1:0] bank, // Bank inputs.
  output logic [ADDR_W-1:0] addr, // Address inputs.
  output logic [1:0] mask, // Byte masks {upper, lower}.
  output logic [DATA_W-1:0] dq // Write data toward the device.
);
  // Idle with select high so nothing is taken before the first command.
  initial begin
    code = 4'hF;
    bank = '0;
    addr = '0;
    mask = 2'h0;
    dq = '0;
  end
  // One command cycle; returns just after the edge that samples it.
  task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge mem_clk);
    code <= c;
    bank <= b;
    addr <= a;
    @(posedge mem_clk);
    code <= CMD_NOP;
  endtask : send
  // Write burst of two beats; the lines are flipped after the hold so stale data never matches.
  task automatic wr(input logic [2:0] b, input logic [13:0] a, input logic [31:0] w,
                    input logic [3:0] m);
    send(CMD_WRITE, b, a);
    dq <= w[15:0];
    mask <= m[1:0];
    @(posedge mem_clk);
    dq <= w[31:16];
    mask <= m[3:2];
    @(posedge mem_clk);
    dq <= ~dq;
    mask <= ~mask;
  endtask : wr
endmodule : ddr_ctrl_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import ddr_pin_pkg::*;
  logic clock = 1'b0; // Core clock, 50 ns.
  logic mem_clk = 1'b0; // Link clock, 12 ns.
  logic rst = 1'b1; // Core reset.
  logic rec_ready = 1'b0; // Core accept, random.
  logic die_term = 1'b0; // Termination request.
  logic strobe_n_en = 1'b1; // Expected complement strobe enable.
  int num_errors = 0; // Mismatches.
  int n_checks = 0; // Comparisons.
  logic [31:0] mem [BANKS]; // Expected word per bank.
  rec_t expq [$]; // Expected records.
  rec_t exp_rec; // Oldest expected record.
  logic wide = 1'b1; // Organisation strap, high for sixteen-bit.
  logic [13:0] emr; // Value written to ext_mode_reg_one.
  rec_t rec_data;
  logic rec_valid, dropped, term_on, lso, lso_oe, lsn_oe, uso_oe, ros_oe;
  logic [7:0] bank_open;
  logic [13:0] base_mode, ext_mode_one, addr;
  logic [15:0] dq, dout;
  logic [1:0] dq_oe, mask;
  logic [3:0] code;
  logic [2:0] bank;
  always #25 clock = ~clock;
  // The link clock is offset so its edges never meet the core clock edges.
  initial begin
    #2.5;
    forever #6 mem_clk = ~mem_clk;
  end
  ddr_ctrl_model ctrl (.mem_clk(mem_clk), .code(code), .bank(bank), .addr(addr), .mask(mask),
    .dq(dq));
  // Strobes rise mid-beat and clock enable stays high throughout.
  ddr_pin_device uut (.clock(clock), .rst(rst), .org_wide(wide), .rec_data(rec_data),
    .rec_valid(rec_valid), .rec_ready(rec_ready), .bank_open(bank_open), .base_mode(base_mode),
    .ext_mode_one(ext_mode_one), .dropped(dropped), .dropped_clear(1'b0), .mem_clk(mem_clk),
    .clk_enable(1'b1), .chip_sel_n(code[3]), .row_strobe_n(code[2]), .col_strobe_n(code[1]),
    .write_en_n(code[0]), .bank_select(bank), .addr_in(addr), .die_termination_ctrl(die_term),
    .lower_byte_mask(mask[0]), .upper_byte_mask(mask[1]), .data_lines_in(dq),
    .data_lines_out(dout), .data_lines_oe(dq_oe), .lower_lane_strobe_in(!mem_clk),
    .lower_lane_strobe_out(lso), .lower_lane_strobe_oe(lso_oe), .lower_lane_strobe_n_out(),
    .lower_lane_strobe_n_oe(lsn_oe), .upper_lane_strobe_in(!mem_clk), .upper_lane_strobe_out(),
    .upper_lane_strobe_oe(uso_oe), .upper_lane_strobe_n_out(), .upper_lane_strobe_n_oe(),
    .read_only_strobe_out(), .read_only_strobe_oe(ros_oe), .term_on(term_on));
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Each taken record must be the oldest expected one; acceptance is random to stall the stream.
  always @(posedge clock) begin
    if (!rst && rec_valid && rec_ready) begin
      exp_rec = (expq.size() != 0) ? expq.pop_front() : 'x;
      chk("record", 32'({exp_rec.cmd, exp_rec.bank, exp_rec.addr}),
          32'({rec_data.cmd, rec_data.bank, rec_data.addr}));
      chk("write data", exp_rec.data, rec_data.data);
      chk("write keep", 32'(exp_rec.keep), 32'(rec_data.keep));
    end
    rec_ready <= ($urandom_range(0, 1) == 1);
  end
  // A forwarded command must reach the core before the next one, or it would be dropped.
  task automatic issue(input cmd_t c, input logic [2:0] b, input logic [13:0] a,
                       input logic [31:0] w = 0, input logic [3:0] mk = 0);
    logic [3:0] kp; // Bytes expected to land; byte-wide keeps byte 0 of each beat only.
    kp = (c != CMD_WRITE) ? 4'h0 : wide ? ~mk : emr[11] ? 4'h5 : ~mk & 4'h5;
    expq.push_back(rec_t'({c, b, a, w, kp}));
    if (c == CMD_WRITE) begin
      ctrl.wr(b, a, w, mk);
      for (int i = 0; i < 4; i++) if (kp[i]) mem[b][8*i +: 8] = w[8*i +: 8];
    end else ctrl.send(c, b, a);
    for (int k = 0; c == CMD_READ && k < 2; k++) begin
      @(negedge mem_clk);
      chk("read data", 32'(mem[b][16*k +: 16] & {{8{wide}}, 8'hFF}),
          32'(dout & {{8{wide}}, 8'hFF}));
      chk("strobes", {25'h0, dq_oe, lso, lso_oe, lsn_oe, uso_oe, ros_oe},
          {25'h0, wide, 1'b1, k == 0, 1'b1, strobe_n_en, wide, !wide && emr[11]});
    end
    for (int i = 0; i < 300 && expq.size() != 0; i++) @(posedge clock);
    if (expq.size() != 0) begin
      num_errors++;
      conclude();
    end
    repeat (2) @(posedge clock);
  endtask : issue
  initial begin
    void'($urandom(32'h0eeec587));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    die_term <= 1'b1;
    repeat (10) @(posedge clock);
    for (int b = 0; b < 4; b++) begin
      // The last pass runs byte-wide with the read-only strobe in place of the mask.
      wide <= (b != 3);
      emr = b[0] ? (b[1] ? 14'h0804 : 14'h0004) : 14'h0400;
      strobe_n_en = ~emr[10];
      ctrl.send(4'h8, MR_EXT1_SEL, 14'h0840);
      issue(CMD_MODE_SET, MR_EXT1_SEL, emr);
      chk("ext mode", 32'(emr), 32'(ext_mode_one));
      chk("termination", 32'(emr[2]), 32'(term_on));
      issue(CMD_ACTIVATE, 3'(b), 14'($urandom));
      issue(CMD_WRITE, 3'(b), 14'($urandom) & 14'h3BFF, $urandom, 4'h0);
      issue(CMD_WRITE, 3'(b), 14'($urandom) & 14'h3BFF, $urandom, 4'($urandom));
      issue(CMD_READ, 3'(b), 14'($urandom) & 14'h3BFF);
    end
    issue(CMD_MODE_SET, MR_BASE_SEL, 14'h0123);
    chk("base mode", 32'h0123, 32'(base_mode));
    chk("open banks", 32'h0F, 32'(bank_open));
    issue(CMD_PRECHARGE, 3'h1, 14'h0000);
    chk("open banks", 32'h0D, 32'(bank_open));
    issue(CMD_PRECHARGE, 3'h0, 14'h0400);
    chk("open banks", 32'h00, 32'(bank_open));
    issue(CMD_REFRESH, 3'h0, 14'h0000);
    chk("dropped", 32'h0, 32'(dropped));
    conclude();
  end
endmodule : tb
